// >>> testbench/sleep_wake_sequencer_bench.sv
// Bench joining the sequencer and the CPU end over the halt link
`timescale 1ns/100ps
module sleep_wake_sequencer_bench;
  localparam int LS_HALF = 3052; // Near 32 kHz in pclk cycles
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic lsclk, irq_unmasked, precision_reset_comparator_cmp, lvd_cmp, pd, osc_en, osc_ok, fci, prr, lsd, wdc, stc;
  logic [1:0] rlev;
  logic [2:0] trip;
  int miscompares, cmp_count, ls_cnt, t0, cyc;
  swk_if link ();
  swk_sequencer u_swk_sequencer (.pclk(pclk), .presetn(presetn), .cpu(link.dev), .lsclk(lsclk),
    .irq_unmasked(irq_unmasked), .precision_reset_comparator_cmp(precision_reset_comparator_cmp), .lvd_cmp(lvd_cmp), .chip_power_down(pd),
    .lowspeed_osc_en(osc_en), .clk_force_internal(fci), .internal_osc_stable(osc_ok),
    .monitor_enable(), .reset_level_select(rlev), .trip_level_select(trip),
    .precision_reset_req(prr), .low_supply_detector(lsd), .watchdog_clear(wdc),
    .sleep_timer_clear(stc), .sleep_timer_irq());
  swk_cpu_end u_swk_cpu_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu(link.cpu));
  swk_checker u_swk_checker (.pclk(pclk), .presetn(presetn), .halt_request(link.halt_request),
    .halt_acknowledge(link.halt_acknowledge), .io_addr(link.io_addr), .io_wdata(link.io_wdata),
    .io_wr(link.io_wr), .lsclk(lsclk), .chip_power_down(pd), .clk_force_internal(fci),
    .watchdog_clear(wdc), .sleep_timer_clear(stc));
  // Clock
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // Low-speed clock made from pclk, so its edges stay clean
  always @(posedge pclk) begin
    ls_cnt <= (ls_cnt == LS_HALF - 1) ? 0 : ls_cnt + 1;
    if (ls_cnt == LS_HALF - 1) lsclk <= ~lsclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // I/O access via the CPU end; bank flag from address bit 8, global enable left off
  task automatic io_wr(input logic [8:0] a, input logic [7:0] d);
    apb(1'h1, swk_pkg::APB_FLAGS, {30'h0000_0000, a[8], 1'h0});
    apb(1'h1, swk_pkg::APB_CMD, {16'h0000, d, a[7:0]});
  endtask : io_wr
  task automatic io_rd(input logic [8:0] a);
    apb(1'h1, swk_pkg::APB_FLAGS, {30'h0000_0000, a[8], 1'h0});
    apb(1'h1, swk_pkg::APB_CMD, {15'h0000, 1'h1, 8'h00, a[7:0]});
    repeat (3) @(posedge pclk);
    apb(1'h0, swk_pkg::APB_STATUS, 32'h0000_0000);
    b = rd[15:8];
  endtask : io_rd
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Watchdog; a full run takes about 25000 cycles
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, lsclk, irq_unmasked, precision_reset_comparator_cmp, lvd_cmp} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ls_cnt = 0;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    io_rd(swk_pkg::IOA_SUPPLY_CTRL);
    check(b, 8'h00);
    io_wr(swk_pkg::IOA_SUPPLY_CTRL, 8'h13);
    io_wr(swk_pkg::IOA_SUPPLY_CTRL, 8'h25); // Reserved level and trip codes are ignored
    io_rd(swk_pkg::IOA_SUPPLY_CTRL);
    check(b, 8'h13);
    check({rlev, trip}, 5'h0b);
    io_wr(swk_pkg::IOA_WDT_CLEAR, swk_pkg::WDT_SLEEP_KEY);
    io_wr(swk_pkg::IOA_WDT_CLEAR, 8'h55);
    io_rd(swk_pkg::IOA_WDT_CLEAR);
    check(b, 8'h00);
    precision_reset_comparator_cmp <= 1'h1;
    lvd_cmp <= 1'h1;
    repeat (4) @(posedge pclk);
    check({prr, lsd}, 2'h3);
    io_wr(swk_pkg::IOA_SUPPLY_CTRL, 8'h33);
    repeat (4) @(posedge pclk);
    check(prr, 1'h0);
    io_rd(swk_pkg::IOA_CMP_STATE);
    check(b, 8'h03);
    // First-bank alias of the comparator state must not decode
    io_rd(9'h0e4);
    check(b, 8'h00);
    io_wr(swk_pkg::IOA_DUTY, 8'hc0);
    io_rd(swk_pkg::IOA_DUTY);
    check(b, 8'hc0);
    apb(1'h0, 8'h0c, 32'h0000_0000);
    check(err, 1'h1);
    // Sleep with the stop bit asked for; the CPU end keeps it clear
    io_wr(swk_pkg::IOA_SYS_CTRL, 8'h09);
    wait (pd === 1'h1);
    // Oscillator status follows power-down by one register stage
    repeat (2) @(posedge pclk);
    check({osc_en, osc_ok}, 2'h2);
    apb(1'h1, swk_pkg::APB_CMD, 32'h0000_0000);
    check(err, 1'h1);
    // Interrupt raised just after a low-speed fall gives the longest wake
    wait (lsclk === 1'h1);
    wait (lsclk === 1'h0);
    @(posedge pclk);
    irq_unmasked <= 1'h1;
    t0 = $time;
    wait (link.halt_acknowledge === 1'h0);
    cyc = ($time - t0) / swk_pkg::CLK_PERIOD_NS;
    check(cyc >= swk_pkg::WAKE_MIN_CYC && cyc <= swk_pkg::WAKE_MAX_CYC, 1'h1);
    irq_unmasked <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h0, swk_pkg::APB_STATUS, 32'h0000_0000);
    check(rd[1], 1'h1);
    io_rd(swk_pkg::IOA_SYS_CTRL);
    check(b, 8'h00);
    final_report();
  end
endmodule : sleep_wake_sequencer_bench

// >>> testbench/swk_checker.sv
// Timing checks on the halt link and power-down of the sleep sequencer
`timescale 1ns/100ps
module swk_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Halt link and sequencer outputs
  input wire logic halt_request,
  input wire logic halt_acknowledge,
  input wire logic [8:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic lsclk,
  input wire logic chip_power_down,
  input wire logic clk_force_internal,
  input wire logic watchdog_clear,
  input wire logic sleep_timer_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Entry steps: request, acknowledge, then power-down one pclk cycle on
  sequence s_entry;
    halt_request ##1 halt_acknowledge ##1 chip_power_down;
  endsequence
  // Sleep write in the running state raises the request next cycle
  chk_sleep_request: assert property (io_wr && io_addr == swk_pkg::IOA_SYS_CTRL && io_wdata[3]
    && !halt_request && !halt_acknowledge |=> halt_request) else $error("no halt request");
  chk_entry_order: assert property ($rose(halt_request) |-> s_entry)
    else $error("sleep entry order broken");
  chk_force_clock: assert property ($rose(chip_power_down) |-> clk_force_internal)
    else $error("clock not forced internal");
  chk_halt_held: assert property (chip_power_down |-> halt_request)
    else $error("halt request dropped while powered down");
  chk_wdt_clear: assert property (io_wr && io_addr == swk_pkg::IOA_WDT_CLEAR |=> watchdog_clear)
    else $error("watchdog not cleared");
  chk_timer_key: assert property (io_wr && io_addr == swk_pkg::IOA_WDT_CLEAR
    |=> sleep_timer_clear == ($past(io_wdata) == swk_pkg::WDT_SLEEP_KEY)) else $error("key clear wrong");
  // One sync stage of slack on the low-speed edges
  chk_pd_on_rise: assert property ($fell(chip_power_down) |-> ($past(lsclk) && !$past(lsclk, 2))
    || ($past(lsclk, 2) && !$past(lsclk, 3))) else $error("power-down not dropped on rise");
  chk_halt_on_fall: assert property ($fell(halt_request) |-> (!$past(lsclk) && $past(lsclk, 2))
    || (!$past(lsclk, 2) && $past(lsclk, 3))) else $error("halt not dropped on fall");
  chk_ack_release: assert property ($fell(halt_request) |=> !halt_acknowledge)
    else $error("acknowledge held after release");
endmodule : swk_checker

// >>> verilog/swk_cpu_end.sv
// CPU end of the halt handshake, ordered by software over APB
`timescale 1ns/100ps
module swk_cpu_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer side
  swk_if.cpu cpu
);

  logic pready_ff, pslverr_ff, ack_ff, gie_ff, xio_ff, step_ff, resumed_ff, isr_ff;
  logic io_wr_ff, io_rd_ff, io_rd_q_ff;
  logic [31:0] prdata_ff;
  logic [7:0] rdata_ff, io_wdata_ff;
  logic [8:0] io_addr_ff;
  logic [8:0] cmd_addr;
  logic acc, done, busy, map_ok, cmd_bad;

  // First access cycle, and the completing edge where writes take effect
  assign acc = psel && penable && !pready_ff;
  assign done = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign busy = ack_ff || cpu.halt_request || io_wr_ff || io_rd_ff;
  assign map_ok = (paddr == swk_pkg::APB_CMD) || (paddr == swk_pkg::APB_STATUS)
    || (paddr == swk_pkg::APB_FLAGS);
  assign cmd_bad = pwrite && (paddr == swk_pkg::APB_CMD) && busy;
  // Bank flag forms address bit 8
  assign cmd_addr = {xio_ff, pwdata[swk_pkg::CMD_ADDR_LSB +: 8]};

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= swk_pkg::WORD_ZERO;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && (!map_ok || cmd_bad);
      if (acc && !pwrite) begin
        prdata_ff <= swk_pkg::WORD_ZERO;
        if (paddr == swk_pkg::APB_STATUS) begin
          prdata_ff[swk_pkg::STS_HALTED_BIT] <= ack_ff;
          prdata_ff[swk_pkg::STS_RESUMED_BIT] <= resumed_ff;
          prdata_ff[swk_pkg::STS_ISR_BIT] <= isr_ff;
          prdata_ff[swk_pkg::STS_RDATA_LSB +: 8] <= rdata_ff;
        end else if (paddr == swk_pkg::APB_FLAGS) begin
          prdata_ff[swk_pkg::FLG_GIE_BIT] <= gie_ff;
          prdata_ff[swk_pkg::FLG_XIO_BIT] <= xio_ff;
        end
      end
    end
  end

  // CPU flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_ff <= 1'b0;
      xio_ff <= 1'b0;
    end else if (done && paddr == swk_pkg::APB_FLAGS) begin
      gie_ff <= pwdata[swk_pkg::FLG_GIE_BIT];
      xio_ff <= pwdata[swk_pkg::FLG_XIO_BIT];
    end
  end

  // One I/O instruction per command; never issued while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      io_addr_ff <= 9'h000;
      io_wdata_ff <= swk_pkg::BYTE_ZERO;
    end else if (done && paddr == swk_pkg::APB_CMD && !busy) begin
      io_wr_ff <= !pwdata[swk_pkg::CMD_READ_BIT];
      io_rd_ff <= pwdata[swk_pkg::CMD_READ_BIT];
      io_addr_ff <= cmd_addr;
      io_wdata_ff <= pwdata[swk_pkg::CMD_DATA_LSB +: 8];
      if (cmd_addr == swk_pkg::IOA_SYS_CTRL) begin
        io_wdata_ff[swk_pkg::SYS_STOP_BIT] <= 1'b0;
      end
    end else begin
      io_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
    end
  end

  // Read data arrives one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_rd_q_ff <= 1'b0;
      rdata_ff <= swk_pkg::BYTE_ZERO;
    end else begin
      io_rd_q_ff <= io_rd_ff;
      if (io_rd_q_ff) begin
        rdata_ff <= cpu.io_rdata;
      end
    end
  end

  // Halt handshake: acknowledge follows the request by one edge each way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      ack_ff <= cpu.halt_request;
      step_ff <= ack_ff && !cpu.halt_request;
    end
  end

  // Sticky status; set wins over a one-to-clear write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resumed_ff <= 1'b0;
      isr_ff <= 1'b0;
    end else begin
      if (step_ff) begin
        resumed_ff <= 1'b1;
      end else if (done && paddr == swk_pkg::APB_STATUS
        && pwdata[swk_pkg::STS_RESUMED_BIT]) begin
        resumed_ff <= 1'b0;
      end
      // No service entry until the instruction after sleep has run
      if (gie_ff && cpu.irq_pending && !ack_ff && !cpu.halt_request && !step_ff) begin
        isr_ff <= 1'b1;
      end else if (done && paddr == swk_pkg::APB_STATUS && pwdata[swk_pkg::STS_ISR_BIT]) begin
        isr_ff <= 1'b0;
      end
    end
  end

  // Outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu.halt_acknowledge = ack_ff;
  assign cpu.io_addr = io_addr_ff;
  assign cpu.io_wdata = io_wdata_ff;
  assign cpu.io_wr = io_wr_ff;
  assign cpu.io_rd = io_rd_ff;

endmodule : swk_cpu_end

// >>> verilog/swk_if.sv
// Halt handshake and I/O access between the sequencer and the CPU core
`timescale 1ns/100ps
interface swk_if;
  logic halt_request;
  logic halt_acknowledge;
  logic [8:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic irq_pending;
  modport dev (
    output halt_request, io_rdata, irq_pending,
    input halt_acknowledge, io_addr, io_wdata, io_wr, io_rd
  );
  modport cpu (
    input halt_request, io_rdata, irq_pending,
    output halt_acknowledge, io_addr, io_wdata, io_wr, io_rd
  );
endinterface : swk_if

// >>> verilog/swk_pkg.sv
// Shared constants and types for the sleep and wakeup sequencer and its CPU end
package swk_pkg;
  // CPU I/O space; address bit 8 is the second bank
  localparam int IO_AW = 9;
  localparam logic [8:0] IOA_SYS_CTRL = 9'h0ff;
  localparam logic [8:0] IOA_WDT_CLEAR = 9'h0e3;
  localparam logic [8:0] IOA_SUPPLY_CTRL = 9'h1e3;
  localparam logic [8:0] IOA_CMP_STATE = 9'h1e4;
  localparam logic [8:0] IOA_DUTY = 9'h1eb;
  localparam logic [7:0] WDT_SLEEP_KEY = 8'h38;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // system_status_control fields
  localparam int SYS_SLEEP_BIT = 3;
  localparam int SYS_STOP_BIT = 0;
  // supply_monitor_control fields
  localparam int RLEV_LSB = 4;
  localparam int TRIP_LSB = 0;
  localparam logic [1:0] RLEV_27V = 2'h0;
  localparam logic [1:0] RLEV_30V = 2'h1;
  localparam logic [1:0] RLEV_RESERVED = 2'h2;
  localparam logic [2:0] TRIP_MAX = 3'h3;
  localparam logic [1:0] RLEV_RST = 2'h0;
  localparam logic [2:0] TRIP_RST = 3'h0;
  // Comparator state and duty register fields
  localparam int CMP_PRECISION_RESET_COMPARATOR_BIT = 0;
  localparam int CMP_LVD_BIT = 1;
  localparam int DUTY_LSB = 6;
  localparam logic [1:0] DUTY_RST = 2'h0;
  // Monitor on/off periods in low-speed clock periods
  localparam logic [9:0] DUTY_P128 = 10'h080;
  localparam logic [9:0] DUTY_P512 = 10'h200;
  localparam logic [9:0] DUTY_P32 = 10'h020;
  localparam logic [9:0] DUTY_P8 = 10'h008;
  // Low-speed clock counts
  localparam logic [15:0] SLEEP_TIMER_TICKS = 16'h0200;
  localparam logic [1:0] OSC_RECOVERY_TICKS = 2'h3;
  // Wakeup time bounds, interrupt to running CPU
  localparam int CLK_PERIOD_NS = 5;
  localparam int WAKE_MIN_US = 75;
  localparam int WAKE_MAX_US = 105;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYC = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
  // APB map of the CPU end
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_FLAGS = 8'h08;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int FLG_GIE_BIT = 0;
  localparam int FLG_XIO_BIT = 1;
  localparam int STS_HALTED_BIT = 0;
  localparam int STS_RESUMED_BIT = 1;
  localparam int STS_ISR_BIT = 2;
  localparam int STS_RDATA_LSB = 8;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [5:0] {
    SEQ_RUN = 6'b000001,
    SEQ_HALT_WAIT = 6'b000010,
    SEQ_ASLEEP = 6'b000100,
    SEQ_SYNC = 6'b001000,
    SEQ_PWRUP = 6'b010000,
    SEQ_SETTLE = 6'b100000
  } swk_seq_e;
endpackage : swk_pkg

// >>> verilog/swk_sequencer.sv
// Sleep and wakeup sequencer, device end of the halt handshake
`timescale 1ns/100ps
// Functional notes
// - Watchdog-clear write clears watchdog; key clears timer
// - Sleep only via sleep bit; interrupt wakes
// - Supply monitor duty-cycled while asleep
// - Low-speed oscillator runs throughout sleep
// - Any unmasked interrupt wakes, enable flag ignored
// - Firmware keeps stop bit clear to resume
// - Force internal clock; three-tick oscillator recovery
// - External oscillator is never powered down
// - CPU runs next instruction before service routine
// - Sleep timer interrupt fires periodically always
// - Sleep bit raises halt request at once
// - Acknowledge, then power-down one half-cycle later; here one pclk cycle later
// - Power-down stops flash, oscillator, filter, bandgap
// - Wake interrupt synchronised on low-speed falling edge
// - Next low-speed rising edge negates power-down
// - Following rising edge samples settled comparators
// - Next falling edge drops halt; CPU resumes
// - Wakeup time stays within 75 to 105 us; here two to three low-speed periods, about 61 to 92 us at the bench clock
// - Supply-monitor control only in second I/O bank
// - Reset level selects trip or no reset
// - Trip level codes 000 to 011 valid only
// - Duty field picks 128, 512, 32, 8 periods
// - Firmware writes bit 3 to request sleep
module swk_sequencer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // CPU core side
  swk_if.dev cpu,
  // Low-speed clock as a synchronous level, and unmasked interrupts
  input wire logic lsclk,
  input wire logic irq_unmasked,
  // Supply monitor comparators
  input wire logic precision_reset_comparator_cmp,
  input wire logic lvd_cmp,
  // Power and clock control
  output logic chip_power_down,
  output logic lowspeed_osc_en,
  output logic clk_force_internal,
  output logic internal_osc_stable,
  output logic monitor_enable,
  // Supply monitor settings and results
  output logic [1:0] reset_level_select,
  output logic [2:0] trip_level_select,
  output logic precision_reset_req,
  output logic low_supply_detector,
  // Timers
  output logic watchdog_clear,
  output logic sleep_timer_clear,
  output logic sleep_timer_irq
);

  // Period of the monitor duty cycle for a field code
  function automatic logic [9:0] duty_period(input logic [1:0] code);
    case (code)
      2'h0: duty_period = swk_pkg::DUTY_P128;
      2'h1: duty_period = swk_pkg::DUTY_P512;
      2'h2: duty_period = swk_pkg::DUTY_P32;
      default: duty_period = swk_pkg::DUTY_P8;
    endcase
  endfunction : duty_period

  swk_pkg::swk_seq_e state_ff;
  logic ls_q_ff, halt_req_ff, pd_ff, wake_pend_ff, sleep_ff, stop_ff;
  logic mon_ff, clk_force_ff, osc_stable_ff, wdt_clr_ff, st_clr_ff, st_irq_ff, osc_en_ff;
  logic cmp_precision_reset_comparator_ff, cmp_lvd_ff, precision_reset_comparator_req_ff, lvd_out_ff, irq_pend_ff;
  logic [1:0] rlev_ff, duty_ff, osc_cnt_ff;
  logic [2:0] trip_ff;
  logic [9:0] duty_cnt_ff;
  logic [15:0] st_cnt_ff;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ls_rise, ls_fall, wr_sys, wr_wdt, wr_sup, wr_duty, wdt_key, sleep_req;
  logic go_halt, go_pd, go_sync, go_pwrup, go_settle, go_run, cmp_upd;

  // Edges of the low-speed clock, which is sampled as a plain input
  assign ls_rise = lsclk & ~ls_q_ff;
  assign ls_fall = ~lsclk & ls_q_ff;

  // I/O decode; bank 2 registers need address bit 8 set
  assign wr_sys = cpu.io_wr && (cpu.io_addr == swk_pkg::IOA_SYS_CTRL);
  assign wr_wdt = cpu.io_wr && (cpu.io_addr == swk_pkg::IOA_WDT_CLEAR);
  assign wr_sup = cpu.io_wr && (cpu.io_addr == swk_pkg::IOA_SUPPLY_CTRL);
  assign wr_duty = cpu.io_wr && (cpu.io_addr == swk_pkg::IOA_DUTY);
  assign wdt_key = wr_wdt && (cpu.io_wdata == swk_pkg::WDT_SLEEP_KEY);
  assign sleep_req = wr_sys && cpu.io_wdata[swk_pkg::SYS_SLEEP_BIT];

  // Sequence steps
  assign go_halt = (state_ff == swk_pkg::SEQ_RUN) && sleep_req;
  assign go_pd = (state_ff == swk_pkg::SEQ_HALT_WAIT) && cpu.halt_acknowledge;
  // Stop bit set keeps the part asleep
  assign go_sync = (state_ff == swk_pkg::SEQ_ASLEEP) && wake_pend_ff && ls_fall
    && !stop_ff;
  assign go_pwrup = (state_ff == swk_pkg::SEQ_SYNC) && ls_rise;
  assign go_settle = (state_ff == swk_pkg::SEQ_PWRUP) && ls_rise;
  assign go_run = (state_ff == swk_pkg::SEQ_SETTLE) && ls_fall;

  // Low-speed clock history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_q_ff <= 1'b0;
    end else begin
      ls_q_ff <= lsclk;
    end
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= swk_pkg::SEQ_RUN;
    end else begin
      case (state_ff)
        swk_pkg::SEQ_RUN: if (go_halt) state_ff <= swk_pkg::SEQ_HALT_WAIT;
        swk_pkg::SEQ_HALT_WAIT: if (go_pd) state_ff <= swk_pkg::SEQ_ASLEEP;
        swk_pkg::SEQ_ASLEEP: if (go_sync) state_ff <= swk_pkg::SEQ_SYNC;
        swk_pkg::SEQ_SYNC: if (go_pwrup) state_ff <= swk_pkg::SEQ_PWRUP;
        swk_pkg::SEQ_PWRUP: if (go_settle) state_ff <= swk_pkg::SEQ_SETTLE;
        swk_pkg::SEQ_SETTLE: if (go_run) state_ff <= swk_pkg::SEQ_RUN;
        default: state_ff <= swk_pkg::SEQ_RUN;
      endcase
    end
  end

  // Halt request: one level from entry to the last step, never pulsed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_req_ff <= 1'b0;
    end else if (go_halt) begin
      halt_req_ff <= 1'b1;
    end else if (go_run) begin
      halt_req_ff <= 1'b0;
    end
  end

  // Chip power-down; the cycle after acknowledge stands in for the falling CPU edge.
  // The external oscillator is not in this set: firmware owns it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_ff <= 1'b0;
    end else if (go_pd) begin
      pd_ff <= 1'b1;
    end else if (go_pwrup) begin
      pd_ff <= 1'b0;
    end
  end

  // Wake request latch; a short timer pulse between low-speed edges is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pend_ff <= 1'b0;
    end else if (irq_unmasked || st_irq_ff) begin
      wake_pend_ff <= 1'b1;
    end else if (go_sync || (state_ff == swk_pkg::SEQ_RUN)) begin
      wake_pend_ff <= 1'b0;
    end
  end

  // Sleep and stop bits; hardware clears sleep once the CPU is back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else begin
      if (go_halt) begin
        sleep_ff <= 1'b1;
      end else if (go_run) begin
        sleep_ff <= 1'b0;
      end
      if (wr_sys) begin
        stop_ff <= cpu.io_wdata[swk_pkg::SYS_STOP_BIT];
      end
    end
  end

  // Supply monitor settings; reserved codes leave the field unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rlev_ff <= swk_pkg::RLEV_RST;
      trip_ff <= swk_pkg::TRIP_RST;
      duty_ff <= swk_pkg::DUTY_RST;
    end else begin
      if (wr_sup && cpu.io_wdata[swk_pkg::RLEV_LSB +: 2] != swk_pkg::RLEV_RESERVED) begin
        rlev_ff <= cpu.io_wdata[swk_pkg::RLEV_LSB +: 2];
      end
      if (wr_sup && cpu.io_wdata[swk_pkg::TRIP_LSB +: 3] <= swk_pkg::TRIP_MAX) begin
        trip_ff <= cpu.io_wdata[swk_pkg::TRIP_LSB +: 3];
      end
      if (wr_duty) begin
        duty_ff <= cpu.io_wdata[swk_pkg::DUTY_LSB +: 2];
      end
    end
  end

  // Monitor duty cycle while powered down, trading latency for current
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_cnt_ff <= 10'h000;
      mon_ff <= 1'b1;
    end else if (!pd_ff) begin
      duty_cnt_ff <= 10'h000;
      mon_ff <= 1'b1;
    end else if (ls_rise) begin
      if (duty_cnt_ff >= 10'(duty_period(duty_ff) - 10'h001)) begin
        duty_cnt_ff <= 10'h000;
        mon_ff <= ~mon_ff;
      end else begin
        duty_cnt_ff <= 10'(duty_cnt_ff + 10'h001);
      end
    end
  end

  // Sleep timer runs in every state; the key write restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cnt_ff <= 16'h0000;
      st_irq_ff <= 1'b0;
    end else if (wdt_key) begin
      st_cnt_ff <= 16'h0000;
      st_irq_ff <= 1'b0;
    end else begin
      st_irq_ff <= 1'b0;
      if (ls_rise) begin
        if (st_cnt_ff >= 16'(swk_pkg::SLEEP_TIMER_TICKS - 16'h0001)) begin
          st_cnt_ff <= 16'h0000;
          st_irq_ff <= 1'b1;
        end else begin
          st_cnt_ff <= 16'(st_cnt_ff + 16'h0001);
        end
      end
    end
  end

  // Watchdog and timer clear pulses; any data clears the watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clr_ff <= 1'b0;
      st_clr_ff <= 1'b0;
    end else begin
      wdt_clr_ff <= wr_wdt;
      st_clr_ff <= wdt_key;
    end
  end

  // Clock select force and internal oscillator recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_force_ff <= 1'b0;
      osc_cnt_ff <= 2'h0;
      osc_stable_ff <= 1'b1;
      osc_en_ff <= 1'b0;
    end else begin
      // Low-speed oscillator stays on in every state, sleep included
      osc_en_ff <= 1'b1;
      clk_force_ff <= go_pd;
      if (pd_ff) begin
        osc_cnt_ff <= 2'h0;
        osc_stable_ff <= 1'b0;
      end else if (ls_rise && !osc_stable_ff) begin
        osc_cnt_ff <= 2'(osc_cnt_ff + 2'h1);
        osc_stable_ff <= (2'(osc_cnt_ff + 2'h1) == swk_pkg::OSC_RECOVERY_TICKS);
      end
    end
  end

  // Comparators follow while awake, hold while unsettled or duty-off
  assign cmp_upd = (state_ff == swk_pkg::SEQ_RUN) || (state_ff == swk_pkg::SEQ_HALT_WAIT)
    || (state_ff == swk_pkg::SEQ_SETTLE) || go_settle
    || ((state_ff == swk_pkg::SEQ_ASLEEP) && mon_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_precision_reset_comparator_ff <= 1'b0;
      cmp_lvd_ff <= 1'b0;
      precision_reset_comparator_req_ff <= 1'b0;
      lvd_out_ff <= 1'b0;
    end else begin
      if (cmp_upd) begin
        cmp_precision_reset_comparator_ff <= precision_reset_comparator_cmp;
        cmp_lvd_ff <= lvd_cmp;
      end
      // Level 11 leaves the comparator readable but raises no reset
      precision_reset_comparator_req_ff <= cmp_precision_reset_comparator_ff && ((rlev_ff == swk_pkg::RLEV_27V)
        || (rlev_ff == swk_pkg::RLEV_30V));
      lvd_out_ff <= cmp_lvd_ff;
    end
  end

  // Read data, one cycle after the read strobe
  always_comb begin
    nxt_rdata = swk_pkg::BYTE_ZERO;
    case (cpu.io_addr)
      swk_pkg::IOA_SYS_CTRL: begin
        nxt_rdata[swk_pkg::SYS_SLEEP_BIT] = sleep_ff;
        nxt_rdata[swk_pkg::SYS_STOP_BIT] = stop_ff;
      end
      swk_pkg::IOA_SUPPLY_CTRL: begin
        nxt_rdata[swk_pkg::RLEV_LSB +: 2] = rlev_ff;
        nxt_rdata[swk_pkg::TRIP_LSB +: 3] = trip_ff;
      end
      swk_pkg::IOA_CMP_STATE: begin
        nxt_rdata[swk_pkg::CMP_PRECISION_RESET_COMPARATOR_BIT] = cmp_precision_reset_comparator_ff;
        nxt_rdata[swk_pkg::CMP_LVD_BIT] = cmp_lvd_ff;
      end
      swk_pkg::IOA_DUTY: nxt_rdata[swk_pkg::DUTY_LSB +: 2] = duty_ff;
      default: nxt_rdata = swk_pkg::BYTE_ZERO;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= swk_pkg::BYTE_ZERO;
      irq_pend_ff <= 1'b0;
    end else begin
      if (cpu.io_rd) begin
        rdata_ff <= nxt_rdata;
      end
      irq_pend_ff <= irq_unmasked || st_irq_ff;
    end
  end

  // Outputs, all from flip-flops; the low-speed oscillator is never gated
  assign cpu.halt_request = halt_req_ff;
  assign cpu.io_rdata = rdata_ff;
  assign cpu.irq_pending = irq_pend_ff;
  assign chip_power_down = pd_ff;
  assign lowspeed_osc_en = osc_en_ff;
  assign clk_force_internal = clk_force_ff;
  assign internal_osc_stable = osc_stable_ff;
  assign monitor_enable = mon_ff;
  assign reset_level_select = rlev_ff;
  assign trip_level_select = trip_ff;
  assign precision_reset_req = precision_reset_comparator_req_ff;
  assign low_supply_detector = lvd_out_ff;
  assign watchdog_clear = wdt_clr_ff;
  assign sleep_timer_clear = st_clr_ff;
  assign sleep_timer_irq = st_irq_ff;

endmodule : swk_sequencer
